//--- bridge_err_pkg.sv
package bridge_err_pkg;
  localparam logic [11:0] OFF_LINK_UNC_SEV   = 12'h10c;
  localparam logic [11:0] OFF_CORR_FLAGS     = 12'h110;
  localparam logic [11:0] OFF_CORR_MASKS     = 12'h114;
  localparam logic [11:0] OFF_ERR_CAP_CTRL   = 12'h118;
  localparam logic [11:0] OFF_LINK_HDR0      = 12'h11c;
  localparam logic [11:0] OFF_LINK_HDR1      = 12'h120;
  localparam logic [11:0] OFF_LINK_HDR2      = 12'h124;
  localparam logic [11:0] OFF_LINK_HDR3      = 12'h128;
  localparam logic [11:0] OFF_BUS_FLAGS      = 12'h12c;
  localparam logic [11:0] OFF_BUS_MASKS      = 12'h130;
  localparam logic [11:0] OFF_BUS_SEV        = 12'h134;
  localparam logic [11:0] OFF_BUS_FEP        = 12'h138;
  localparam logic [11:0] OFF_BUS_LOG0       = 12'h13c;
  localparam logic [11:0] OFF_BUS_LOG1       = 12'h140;
  localparam logic [11:0] OFF_BUS_LOG2       = 12'h144;
  localparam logic [11:0] OFF_BUS_LOG3       = 12'h148;
  localparam logic [11:0] OFF_CHAN_HDR       = 12'h150;
  localparam logic [11:0] OFF_PORT_CAP1      = 12'h154;
  localparam logic [11:0] OFF_PORT_CAP2      = 12'h158;
  localparam logic [11:0] OFF_PORT_CTRL      = 12'h15c;
  localparam logic [11:0] OFF_CH0_CAP        = 12'h160;
  localparam logic [11:0] OFF_CH0_CTRL       = 12'h164;
  localparam logic [11:0] OFF_CH0_STATE      = 12'h168;
  // Implemented bit sets, reset values, field bit positions and fixed read values
  localparam logic [31:0] CORR_FLAG_BITS     = 32'h0000_11c1;
  localparam logic [31:0] CORR_MASK_BITS     = 32'h0000_31c1;
  localparam logic [31:0] CORR_MASK_RESET    = 32'h0000_2000;
  localparam logic [31:0] LINK_SEV_BITS      = 32'h001f_c000;
  localparam logic [31:0] LINK_SEV_RESET     = 32'h0006_0000;
  localparam logic [31:0] BUS_BITS           = 32'h0000_3fef;
  localparam logic [31:0] BUS_MASK_RESET     = 32'h0000_17a8;
  localparam logic [31:0] BUS_SEV_RESET      = 32'h0000_1340;
  localparam int          FEP_LSB            = 0;
  localparam int          ECRC_GEN_CAP_BIT   = 5;
  localparam int          ECRC_GEN_EN_BIT    = 6;
  localparam int          ECRC_CHK_CAP_BIT   = 7;
  localparam int          ECRC_CHK_EN_BIT    = 8;
  localparam logic [31:0] CHAN_HDR_VALUE     = 32'h0001_0002;
  localparam logic [31:0] CH0_CTRL_VALUE     = 32'h8000_00ff;
endpackage

//--- bridge_error_and_vc_capability_regs.sv
`timescale 1ns/10ps
module bridge_error_and_vc_capability_regs
  import bridge_err_pkg::*;
(
  // Clock and resets
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          power_on_rst_n,
  // Register port
  input  wire logic [11:0]   addr,
  input  wire logic [31:0]   wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic      [31:0]   rdata,
  // Link side error events
  input  wire logic [31:0]   link_corr_event,
  input  wire logic [4:0]    link_unc_index,
  input  wire logic          link_unc_event,
  input  wire logic [127:0]  link_header,
  // Bus side error events
  input  wire logic [31:0]   bus_event,
  input  wire logic [35:0]   bus_attr_phase,
  input  wire logic [3:0]    bus_cmd_first,
  input  wire logic [3:0]    bus_cmd_second,
  input  wire logic [31:0]   bus_addr_first,
  input  wire logic [31:0]   bus_addr_second,
  // Control to core
  output logic               ecrc_gen_enable,
  output logic               ecrc_check_enable,
  output logic               bus_error_pending
);
  logic [31:0]  corr_flags;
  logic [31:0]  corr_masks;
  logic [31:0]  link_sev;
  logic [4:0]   link_fep;
  logic         link_logged;
  logic [127:0] link_hdr;
  logic [31:0]  bus_flags;
  logic [31:0]  bus_masks;
  logic [31:0]  bus_sev;
  logic [4:0]   bus_fep;
  logic [127:0] bus_log;
  logic [31:0]  bus_new;
  logic [4:0]   bus_first_idx;
  logic [31:0]  next_rdata;
  logic         ctrl_wr;
  logic         next_bus_load;

  // Sticky state is reset only by power-on reset; rst_n only affects the read path
  // power-on only
  always_ff @(posedge clk or negedge power_on_rst_n) begin
    if (!power_on_rst_n) begin
      corr_flags <= 32'h0000_0000;
    end else begin
      corr_flags <= ((corr_flags & ~((wr && addr == OFF_CORR_FLAGS) ? wdata : 32'h0))
                     | link_corr_event) & CORR_FLAG_BITS;
    end
  end

  always_ff @(posedge clk or negedge power_on_rst_n) begin
    if (!power_on_rst_n) begin
      corr_masks <= CORR_MASK_RESET;
    end else if (wr && addr == OFF_CORR_MASKS) begin
      corr_masks <= wdata & CORR_MASK_BITS;
    end
  end

  always_ff @(posedge clk or negedge power_on_rst_n) begin
    if (!power_on_rst_n) begin
      link_sev <= LINK_SEV_RESET;
    end else if (wr && addr == OFF_LINK_UNC_SEV) begin
      link_sev <= wdata & LINK_SEV_BITS;
    end
  end

  assign ctrl_wr = wr && addr == OFF_ERR_CAP_CTRL;

  always_ff @(posedge clk or negedge power_on_rst_n) begin
    if (!power_on_rst_n) begin
      ecrc_gen_enable   <= 1'b0;
      ecrc_check_enable <= 1'b0;
    end else if (ctrl_wr) begin
      ecrc_gen_enable   <= wdata[ECRC_GEN_EN_BIT];
      ecrc_check_enable <= wdata[ECRC_CHK_EN_BIT];
    end
  end

  // Link log stays frozen until software writes the capability word to rearm it
  // link first error
  always_ff @(posedge clk or negedge power_on_rst_n) begin
    if (!power_on_rst_n) begin
      link_fep    <= 5'h00;
      link_logged <= 1'b0;
      link_hdr    <= 128'h0;
    end else if (link_unc_event && !link_logged) begin
      link_fep    <= link_unc_index;
      link_logged <= 1'b1;
      link_hdr    <= link_header;
    end else if (ctrl_wr) begin
      link_logged <= 1'b0;
    end
  end

  assign bus_new = bus_event & BUS_BITS;

  always_comb begin
    bus_first_idx = 5'h00;
    for (int i = 13; i >= 0; i--) begin
      if (bus_new[i] && !bus_masks[i]) begin
        bus_first_idx = 5'(i);
      end
    end
  end

  assign bus_error_pending = |(bus_flags & ~bus_masks);
  assign next_bus_load     = |(bus_new & ~bus_masks) && !bus_error_pending;

  always_ff @(posedge clk or negedge power_on_rst_n) begin
    if (!power_on_rst_n) begin
      bus_flags <= 32'h0000_0000;
    end else begin
      bus_flags <= ((bus_flags & ~((wr && addr == OFF_BUS_FLAGS) ? wdata : 32'h0))
                    | bus_new) & BUS_BITS;
    end
  end

  always_ff @(posedge clk or negedge power_on_rst_n) begin
    if (!power_on_rst_n) begin
      bus_masks <= BUS_MASK_RESET;
      bus_sev   <= BUS_SEV_RESET;
    end else begin
      if (wr && addr == OFF_BUS_MASKS) begin
        bus_masks <= wdata & BUS_BITS;
      end
      if (wr && addr == OFF_BUS_SEV) begin
        bus_sev <= wdata & BUS_BITS;
      end
    end
  end

  always_ff @(posedge clk or negedge power_on_rst_n) begin
    if (!power_on_rst_n) begin
      bus_fep <= 5'h00;
      bus_log <= 128'h0;
    end else if (next_bus_load) begin
      bus_fep <= bus_first_idx;
      bus_log <= {bus_addr_second, bus_addr_first, 20'h00000,
                  bus_cmd_second, bus_cmd_first, bus_attr_phase};
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (addr)
      OFF_LINK_UNC_SEV: next_rdata = link_sev;
      OFF_CORR_FLAGS:   next_rdata = corr_flags;
      OFF_CORR_MASKS:   next_rdata = corr_masks;
      OFF_ERR_CAP_CTRL: begin
        next_rdata[FEP_LSB +: 5]     = link_fep;
        next_rdata[ECRC_GEN_CAP_BIT] = 1'b1;
        next_rdata[ECRC_GEN_EN_BIT]  = ecrc_gen_enable;
        next_rdata[ECRC_CHK_CAP_BIT] = 1'b1;
        next_rdata[ECRC_CHK_EN_BIT]  = ecrc_check_enable;
      end
      OFF_LINK_HDR0:    next_rdata = link_hdr[127:96];
      OFF_LINK_HDR1:    next_rdata = link_hdr[95:64];
      OFF_LINK_HDR2:    next_rdata = link_hdr[63:32];
      OFF_LINK_HDR3:    next_rdata = link_hdr[31:0];
      OFF_BUS_FLAGS:    next_rdata = bus_flags;
      OFF_BUS_MASKS:    next_rdata = bus_masks;
      OFF_BUS_SEV:      next_rdata = bus_sev;
      OFF_BUS_FEP:      next_rdata = {27'h0, bus_fep};
      OFF_BUS_LOG0:     next_rdata = bus_log[31:0];
      OFF_BUS_LOG1:     next_rdata = bus_log[63:32];
      OFF_BUS_LOG2:     next_rdata = bus_log[95:64];
      OFF_BUS_LOG3:     next_rdata = bus_log[127:96];
      OFF_CHAN_HDR:     next_rdata = CHAN_HDR_VALUE;
      OFF_CH0_CTRL:     next_rdata = CH0_CTRL_VALUE;
      default:          next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // Assertions
  property p_corr_w1c;
    @(posedge clk) disable iff (!power_on_rst_n)
      (wr && addr == OFF_CORR_FLAGS && wdata[0] && !link_corr_event[0]) |=> !corr_flags[0];
  endproperty
  a_corr_w1c: assert property (p_corr_w1c) else $error("corr flag not cleared");

  property p_set_wins;
    @(posedge clk) disable iff (!power_on_rst_n)
      (link_corr_event[6]) |=> corr_flags[6];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("corr event lost");

  property p_zero_keeps;
    @(posedge clk) disable iff (!power_on_rst_n)
      (wr && addr == OFF_BUS_FLAGS && !wdata[7] && bus_flags[7]) |=> bus_flags[7];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared flag");

  property p_reserved4;
    @(posedge clk) disable iff (!power_on_rst_n) !bus_flags[4] && !bus_masks[4];
  endproperty
  a_reserved4: assert property (p_reserved4) else $error("reserved bit 4 set");

  property p_bus_fep_load;
    @(posedge clk) disable iff (!power_on_rst_n)
      next_bus_load |=> bus_fep == $past(bus_first_idx) && bus_log[39:36] == $past(bus_cmd_first);
  endproperty
  a_bus_fep_load: assert property (p_bus_fep_load) else $error("bus log not loaded");

  property p_log_hold;
    @(posedge clk) disable iff (!power_on_rst_n)
      bus_error_pending |=> $stable(bus_log);
  endproperty
  a_log_hold: assert property (p_log_hold) else $error("bus log overwritten");

  property p_log_rsvd;
    @(posedge clk) disable iff (!power_on_rst_n) bus_log[63:44] == 20'h00000;
  endproperty
  a_log_rsvd: assert property (p_log_rsvd) else $error("log reserved bits set");

  property p_chan_read;
    @(posedge clk) disable iff (!rst_n)
      (rd && addr == OFF_CHAN_HDR) |=> rdata == 32'h0001_0002;
  endproperty
  a_chan_read: assert property (p_chan_read) else $error("channel header wrong");

  property p_port_zero;
    @(posedge clk) disable iff (!rst_n)
      (rd && (addr == OFF_PORT_CAP1 || addr == OFF_PORT_CTRL)) |=> rdata == 32'h0;
  endproperty
  a_port_zero: assert property (p_port_zero) else $error("port channel nonzero");

  property p_cap_ones;
    @(posedge clk) disable iff (!rst_n)
      (rd && addr == OFF_ERR_CAP_CTRL) |=> rdata[5] && rdata[7] && rdata[31:9] == 23'h0;
  endproperty
  a_cap_ones: assert property (p_cap_ones) else $error("capability bits wrong");

  property p_read_one;
    @(posedge clk) disable iff (!rst_n) !rd |=> rdata == 32'h0;
  endproperty
  a_read_one: assert property (p_read_one) else $error("read data outside slot");

  property p_corr_rsvd;
    @(posedge clk) disable iff (!power_on_rst_n)
      (corr_flags & ~CORR_FLAG_BITS) == 32'h0000_0000;
  endproperty
  a_corr_rsvd: assert property (p_corr_rsvd) else $error("corr reserved flag set");

  property p_mask_write;
    @(posedge clk) disable iff (!power_on_rst_n)
      (wr && addr == OFF_CORR_MASKS) |=> corr_masks == ($past(wdata) & CORR_MASK_BITS);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("corr mask write lost");

  property p_sev_write;
    @(posedge clk) disable iff (!power_on_rst_n)
      (wr && addr == OFF_LINK_UNC_SEV) |=> link_sev == ($past(wdata) & LINK_SEV_BITS);
  endproperty
  a_sev_write: assert property (p_sev_write) else $error("link severity write lost");

  property p_ecrc_write;
    @(posedge clk) disable iff (!power_on_rst_n)
      ctrl_wr |=> ecrc_gen_enable == $past(wdata[ECRC_GEN_EN_BIT])
        && ecrc_check_enable == $past(wdata[ECRC_CHK_EN_BIT]);
  endproperty
  a_ecrc_write: assert property (p_ecrc_write) else $error("ECRC enable write lost");

  property p_link_capture;
    @(posedge clk) disable iff (!power_on_rst_n)
      (link_unc_event && !link_logged) |=> link_hdr == $past(link_header)
        && link_fep == $past(link_unc_index);
  endproperty
  a_link_capture: assert property (p_link_capture) else $error("link log not captured");

  property p_link_hold;
    @(posedge clk) disable iff (!power_on_rst_n)
      link_logged |=> $stable(link_hdr) && $stable(link_fep);
  endproperty
  a_link_hold: assert property (p_link_hold) else $error("link log overwritten");

  property p_bus_set;
    @(posedge clk) disable iff (!power_on_rst_n)
      (|bus_new) |=> (bus_flags & $past(bus_new)) == $past(bus_new);
  endproperty
  a_bus_set: assert property (p_bus_set) else $error("bus event lost");

  property p_bus_mask_write;
    @(posedge clk) disable iff (!power_on_rst_n)
      (wr && addr == OFF_BUS_MASKS) |=> bus_masks == ($past(wdata) & BUS_BITS);
  endproperty
  a_bus_mask_write: assert property (p_bus_mask_write) else $error("bus mask write lost");

  property p_bus_sev_write;
    @(posedge clk) disable iff (!power_on_rst_n)
      (wr && addr == OFF_BUS_SEV) |=> bus_sev == ($past(wdata) & BUS_BITS);
  endproperty
  a_bus_sev_write: assert property (p_bus_sev_write) else $error("bus severity write lost");

  property p_fep_hold;
    @(posedge clk) disable iff (!power_on_rst_n)
      bus_error_pending |=> $stable(bus_fep);
  endproperty
  a_fep_hold: assert property (p_fep_hold) else $error("bus pointer overwritten");

  property p_bus_rsvd;
    @(posedge clk) disable iff (!power_on_rst_n)
      ((bus_flags | bus_masks | bus_sev) & ~BUS_BITS) == 32'h0000_0000;
  endproperty
  a_bus_rsvd: assert property (p_bus_rsvd) else $error("bus reserved bit set");

  property p_ch0_read;
    @(posedge clk) disable iff (!rst_n)
      (rd && addr == OFF_CH0_CTRL) |=> rdata == 32'h8000_00ff;
  endproperty
  a_ch0_read: assert property (p_ch0_read) else $error("channel 0 control wrong");

  c_corr_clear: cover property (@(posedge clk) corr_flags[0] ##1 !corr_flags[0]);
  c_bus_load:   cover property (@(posedge clk) next_bus_load);
  c_link_log:   cover property (@(posedge clk) link_unc_event && !link_logged);
  c_ecrc_on:    cover property (@(posedge clk) ecrc_gen_enable && ecrc_check_enable);
  c_bus_clear:  cover property (@(posedge clk) bus_error_pending ##1 !bus_error_pending);
endmodule

//--- bridge_error_and_vc_capability_regs_tb.sv
`timescale 1ns/10ps
module bridge_error_and_vc_capability_regs_tb;
  import bridge_err_pkg::*;
  logic         clk, rst_n, power_on_rst_n, wr, rd, rd_d, link_unc_event;
  logic         ecrc_gen_enable, ecrc_check_enable, bus_error_pending;
  logic [11:0]  addr;
  logic [31:0]  wdata, rdata, link_corr_event, bus_event, r;
  logic [31:0]  bus_addr_first, bus_addr_second;
  logic [4:0]   link_unc_index;
  logic [127:0] link_header, hdr;
  logic [35:0]  bus_attr_phase;
  logic [3:0]   bus_cmd_first, bus_cmd_second;
  logic [31:0]  exp_q[$];
  integer       seed;
  int           mismatches, check_count;

  host_cfg_model i_host (.clk, .addr, .wdata, .wr, .rd);
  bridge_error_and_vc_capability_regs i_dut (.clk, .rst_n, .power_on_rst_n, .addr, .wdata,
    .wr, .rd, .rdata, .link_corr_event, .link_unc_index, .link_unc_event, .link_header,
    .bus_event, .bus_attr_phase, .bus_cmd_first, .bus_cmd_second, .bus_addr_first,
    .bus_addr_second, .ecrc_gen_enable, .ecrc_check_enable, .bus_error_pending);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic print_verdict();
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    i_host.put(a, d, 1'b1);
  endtask

  // The note goes in before the strobe, so the monitor never finds the queue empty
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_host.put(a, 32'h0000_0000, 1'b0);
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d === 1'b1) begin
      check(rdata, exp_q.pop_front());
    end
    rd_d <= rd;
  end

  task automatic check_reset_values();
    rd_chk(OFF_LINK_UNC_SEV, LINK_SEV_RESET);
    rd_chk(OFF_CORR_FLAGS, 32'h0000_0000);
    rd_chk(OFF_CORR_MASKS, CORR_MASK_RESET);
    rd_chk(OFF_ERR_CAP_CTRL, 32'h0000_00a0);
    for (int i = 0; i < 4; i++) rd_chk(OFF_LINK_HDR0 + 12'(4 * i), 32'h0);
    rd_chk(OFF_BUS_FLAGS, 32'h0000_0000);
    rd_chk(OFF_BUS_MASKS, BUS_MASK_RESET);
    rd_chk(OFF_BUS_SEV, BUS_SEV_RESET);
    rd_chk(OFF_BUS_FEP, 32'h0000_0000);
    for (int i = 0; i < 4; i++) rd_chk(OFF_BUS_LOG0 + 12'(4 * i), 32'h0);
    rd_chk(OFF_CHAN_HDR, 32'h0001_0002);
    for (int i = 0; i < 4; i++) rd_chk(OFF_PORT_CAP1 + 12'(4 * i), 32'h0);
    rd_chk(OFF_CH0_CTRL, 32'h8000_00ff);
    rd_chk(OFF_CH0_STATE, 32'h0000_0000);
  endtask

  task automatic pulse_bus(input logic [31:0] ev);
    @(posedge clk);
    bus_event <= ev;
    @(posedge clk);
    bus_event <= 32'h0;
    bus_attr_phase <= ~bus_attr_phase;
    bus_addr_first <= ~bus_addr_first;
  endtask

  initial begin
    seed = 32'h74dbd031;
    {rst_n, power_on_rst_n, link_unc_event, link_unc_index} = '0;
    {link_corr_event, bus_event, bus_addr_first, bus_addr_second} = '0;
    {link_header, bus_attr_phase, bus_cmd_first, bus_cmd_second} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    power_on_rst_n <= 1'b1;
    check_reset_values();
    r = $random(seed);
    hdr = {$random(seed), $random(seed), $random(seed), $random(seed)};
    wr_reg(OFF_CORR_MASKS, r);
    rd_chk(OFF_CORR_MASKS, r & CORR_MASK_BITS);
    wr_reg(OFF_LINK_UNC_SEV, r);
    rd_chk(OFF_LINK_UNC_SEV, r & LINK_SEV_BITS);
    wr_reg(OFF_BUS_MASKS, r);
    rd_chk(OFF_BUS_MASKS, r & BUS_BITS);
    wr_reg(OFF_BUS_SEV, ~r);
    rd_chk(OFF_BUS_SEV, ~r & BUS_BITS);
    wr_reg(OFF_ERR_CAP_CTRL, 32'hffff_ffff);
    rd_chk(OFF_ERR_CAP_CTRL, 32'h0000_01e0);
    check({30'h0, ecrc_check_enable, ecrc_gen_enable}, 32'h3);
    wr_reg(OFF_CHAN_HDR, r);
    rd_chk(OFF_CHAN_HDR, CHAN_HDR_VALUE);
    wr_reg(OFF_CH0_CTRL, 32'h0);
    rd_chk(OFF_CH0_CTRL, CH0_CTRL_VALUE);
    wr_reg(12'h14c, r);
    rd_chk(12'h14c, 32'h0);
    // Link side: second event must not overwrite the first log
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      link_corr_event <= 32'hffff_ffff;
      link_unc_event <= 1'b1;
      link_unc_index <= (k == 0) ? 5'h12 : 5'h03;
      link_header <= (k == 0) ? hdr : ~hdr;
      @(posedge clk);
      link_corr_event <= 32'h0;
      link_unc_event <= 1'b0;
    end
    rd_chk(OFF_CORR_FLAGS, CORR_FLAG_BITS);
    for (int i = 0; i < 4; i++) rd_chk(OFF_LINK_HDR0 + 12'(4 * i), hdr[127 - 32 * i -: 32]);
    rd_chk(OFF_ERR_CAP_CTRL, 32'h0000_01f2);
    wr_reg(OFF_CORR_FLAGS, 32'h0000_0001);
    rd_chk(OFF_CORR_FLAGS, 32'h0000_11c0);
    wr_reg(OFF_CORR_FLAGS, 32'hffff_ffff);
    rd_chk(OFF_CORR_FLAGS, 32'h0000_0000);
    // Bus side log capture
    wr_reg(OFF_BUS_MASKS, 32'h0);
    bus_attr_phase <= {r[3:0], hdr[31:0]};
    bus_cmd_first <= r[7:4];
    bus_cmd_second <= r[11:8];
    bus_addr_first <= hdr[63:32];
    bus_addr_second <= hdr[95:64];
    pulse_bus(32'h0000_0020);
    pulse_bus(32'h0000_0004);
    rd_chk(OFF_BUS_FLAGS, 32'h0000_0024);
    rd_chk(OFF_BUS_FEP, 32'h0000_0005);
    rd_chk(OFF_BUS_LOG0, hdr[31:0]);
    rd_chk(OFF_BUS_LOG1, {20'h0, r[11:8], r[7:4], r[3:0]});
    rd_chk(OFF_BUS_LOG2, hdr[63:32]);
    rd_chk(OFF_BUS_LOG3, hdr[95:64]);
    check({31'h0, bus_error_pending}, 32'h1);
    pulse_bus(32'hffff_ffff);
    rd_chk(OFF_BUS_FLAGS, 32'h0000_3fef);
    // Ordinary reset must leave logged errors in place
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(OFF_BUS_FLAGS, 32'h0000_3fef);
    rd_chk(OFF_BUS_LOG2, hdr[63:32]);
    wr_reg(OFF_BUS_FLAGS, 32'h0000_0020);
    rd_chk(OFF_BUS_FLAGS, 32'h0000_3fcf);
    wr_reg(OFF_BUS_FLAGS, 32'hffff_ffff);
    rd_chk(OFF_BUS_FLAGS, 32'h0000_0000);
    check({31'h0, bus_error_pending}, 32'h0);
    pulse_bus(32'h0000_2000);
    rd_chk(OFF_BUS_FEP, 32'h0000_000d);
    rd_chk(OFF_BUS_LOG0, ~hdr[31:0]);
    rd_chk(OFF_BUS_LOG2, ~hdr[63:32]);
    @(posedge clk);
    power_on_rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    power_on_rst_n <= 1'b1;
    check_reset_values();
    repeat (3) @(posedge clk);
    print_verdict();
  end

  // Whole run is a few hundred cycles; this margin only catches a hang
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule

//--- host_cfg_model.sv
`timescale 1ns/10ps
module host_cfg_model (
  // Clock
  input  wire logic        clk,
  // Register port
  output logic      [11:0] addr,
  output logic      [31:0] wdata,
  output logic             wr,
  output logic             rd
);
  initial begin
    addr  = 12'h000;
    wdata = 32'h0000_0000;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // One strobe cycle, then an idle edge so a raise never meets a release
  task automatic put(input logic [11:0] a, input logic [31:0] d, input logic w);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    @(posedge clk);
    wr    <= 1'b0;
    rd    <= 1'b0;
    wdata <= ~d;
  endtask
endmodule
